/* fas_defs.svh */
// Purpose: Constants for the byte-wide ferroelectric memory host controller
// Assumes: 125 MHz controller clock, 15-bit byte address, 8-bit data
// Notes: Times in ns; cycle counts derived from the clock period
//
// Operation
// - No row spans two blocks; place data of unlike wear in separate blocks.
// - The host puts a stable new address out before pulling chip enable low.
// - The host makes a fresh falling enable edge for every single access.
// - Chip enable returns high after each access so the array can precharge.
// - Write low at the enable fall makes a write and the device leaves data alone.
`ifndef FAS_DEFS_SVH
`define FAS_DEFS_SVH

`define FAS_CLK_PERIOD_NS 8
`define FAS_ADDR_W 15
`define FAS_DATA_W 8
// Block field is the five upper address bits
`define FAS_BLK_LSB 10
`define FAS_ROW_MSB 7
`define FAS_COL_LSB 8
`define FAS_COL_MSB 9
// Top sixteen byte addresses are the settings window
`define FAS_SET_BASE 15'h7ff0
// Timing figures as printed, in ns
`define FAS_T_CA_MIN_NS 70
`define FAS_T_PC_MIN_NS 60
`define FAS_T_CE_MAX_NS 70
`define FAS_T_AS_MIN_NS 8
`define FAS_T_AH_MIN_NS 10
// Least times round up to whole cycles
`define FAS_CYC_UP(ns) (((ns) + `FAS_CLK_PERIOD_NS - 1) / `FAS_CLK_PERIOD_NS)
`define FAS_CA_CYC `FAS_CYC_UP(`FAS_T_CA_MIN_NS)
`define FAS_PC_CYC `FAS_CYC_UP(`FAS_T_PC_MIN_NS)
`define FAS_AS_CYC `FAS_CYC_UP(`FAS_T_AS_MIN_NS)
`define FAS_AH_CYC `FAS_CYC_UP(`FAS_T_AH_MIN_NS)

`endif

/* fas_pkg.sv */
// Purpose: Types for the memory host controller
// Assumes: fas_defs.svh supplies widths
// Notes: Request and answer travel as packed structs
`default_nettype none
`include "fas_defs.svh"
package fas_pkg;
    typedef struct packed {
        logic write;
        logic [`FAS_ADDR_W-1:0] addr;
        logic [`FAS_DATA_W-1:0] wdata;
    } fas_req_t;

    typedef struct packed {
        logic [4:0] block;
        logic [1:0] column;
        logic [7:0] row;
        logic settings;
    } fas_loc_t;

    typedef enum logic [2:0] {
        FAS_IDLE = 3'b000,
        FAS_SETUP = 3'b001,
        FAS_ACTIVE = 3'b010,
        FAS_HOLD = 3'b011,
        FAS_PRECH = 3'b100
    } fas_state_t;
endpackage
`default_nettype wire

/* fas_sync3.sv */
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to i_mclk
// Notes: Output changes only when stages two and three agree
`default_nettype none
module fas_sync3 #(
    parameter int W = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    wire logic [W-1:0] agree = ~(s2_reg ^ s3_reg);
    wire logic [W-1:0] q_next = (agree & s3_reg) | (~agree & o_q);

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            o_q <= '0;
        end
        else
        begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            o_q <= q_next;
        end
    end
endmodule // fas_sync3
`default_nettype wire

/* fas_host.sv */
// Purpose: Host controller strobing a byte-wide ferroelectric memory
// Assumes: One request at a time; device timing from fas_defs.svh
// Notes: Every access gets its own falling chip enable and a precharge gap
// Notes: Settings addresses are not blocked; the requester sees them in o_rsp_loc
`default_nettype none
`include "fas_defs.svh"
module fas_host
    import fas_pkg::*;
#(
    parameter int PRECHARGE_CYC = `FAS_PC_CYC,
    parameter int ACTIVE_CYC = `FAS_CA_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_req_valid,
    input wire fas_req_t i_req,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [`FAS_DATA_W-1:0] o_rsp_rdata,
    output fas_loc_t o_rsp_loc,
    output logic [`FAS_ADDR_W-1:0] o_mem_addr,
    output logic o_mem_ce_n,
    output logic o_mem_we_n,
    output logic o_mem_oe_n,
    input wire logic [`FAS_DATA_W-1:0] i_mem_dq,
    output logic [`FAS_DATA_W-1:0] o_mem_dq,
    output logic o_mem_dq_oe
);
    // ============================================================
    // Reset release
    logic rst_a_reg;
    logic rst_n_reg;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_a_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_a_reg <= 1'b1;
            rst_n_reg <= rst_a_reg;
        end
    end

    // ============================================================
    // Address decode
    function automatic fas_loc_t fas_decode(input logic [`FAS_ADDR_W-1:0] a);
        fas_loc_t l;
        l.block = a[`FAS_ADDR_W-1:`FAS_BLK_LSB];
        l.column = a[`FAS_COL_MSB:`FAS_COL_LSB];
        l.row = a[`FAS_ROW_MSB:0];
        l.settings = (a >= `FAS_SET_BASE);
        return l;
    endfunction

    // ============================================================
    // Data input synchroniser
    wire logic [`FAS_DATA_W-1:0] dq_sync;
    fas_sync3 #(
        .W(`FAS_DATA_W)
    ) u_dq_sync (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n_reg),
        .i_d(i_mem_dq),
        .o_q(dq_sync)
    );

    // ============================================================
    // Sequencer
    localparam int CW = 16;
    localparam int SYNC_CYC = 3;
    // Read data sampled after sync latency on top of the active window
    localparam logic [CW-1:0] ACT_N = CW'(ACTIVE_CYC + SYNC_CYC);
    localparam logic [CW-1:0] PC_N = CW'(PRECHARGE_CYC);
    localparam logic [CW-1:0] AS_N = CW'(`FAS_AS_CYC);
    localparam logic [CW-1:0] AH_N = CW'(`FAS_AH_CYC);

    fas_state_t state_reg;
    fas_state_t state_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    fas_req_t req_reg;
    logic ready_reg;
    logic rsp_valid_reg;
    logic [`FAS_DATA_W-1:0] rdata_reg;
    fas_loc_t loc_reg;
    logic [`FAS_ADDR_W-1:0] addr_reg;
    logic ce_n_reg;
    logic we_n_reg;
    logic oe_n_reg;
    logic dq_oe_reg;

    wire logic cnt_done = (cnt_reg == '0);
    wire logic take = (state_reg == FAS_IDLE) && i_req_valid;
    wire logic finish = (state_reg == FAS_HOLD) && cnt_done;
    wire logic [CW-1:0] cnt_dec = cnt_reg - CW'(1);

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_done ? cnt_reg : cnt_dec;
        unique case (state_reg)
            FAS_IDLE:
            begin
                if (i_req_valid)
                begin
                    // Address goes out first, enable still high
                    state_next = FAS_SETUP;
                    cnt_next = AS_N;
                end
            end
            FAS_SETUP:
            begin
                if (cnt_done)
                begin
                    state_next = FAS_ACTIVE;
                    cnt_next = ACT_N;
                end
            end
            FAS_ACTIVE:
            begin
                if (cnt_done)
                begin
                    state_next = FAS_HOLD;
                    cnt_next = AH_N;
                end
            end
            FAS_HOLD:
            begin
                if (cnt_done)
                begin
                    // Address hold done, enable high since the hold began; gap enforced before the next fall
                    state_next = FAS_PRECH;
                    cnt_next = PC_N;
                end
            end
            FAS_PRECH:
            begin
                if (cnt_done)
                begin
                    state_next = FAS_IDLE;
                end
            end
            default:
            begin
                state_next = FAS_IDLE;
            end
        endcase
    end

    // Pin drive decoded from the next state so pins come from flops
    wire logic ce_n_next = !(state_next == FAS_ACTIVE);
    // Write strobe low before the enable fall: write cycle, device keeps off the bus
    wire logic wr_phase = (state_next == FAS_SETUP) || (state_next == FAS_ACTIVE);
    // At the take the old request still sits in req_reg, so the new one decides
    wire logic we_n_take = !i_req.write;
    wire logic we_n_hold = !(req_reg.write && wr_phase);
    wire logic we_n_next = take ? we_n_take : we_n_hold;
    // Output enable low only while a read holds the enable low
    wire logic oe_n_next = !(!req_reg.write && state_next == FAS_ACTIVE) || take;
    wire logic dq_oe_next = take ? i_req.write : (req_reg.write && state_next != FAS_IDLE);
    wire logic ready_next = (state_next == FAS_IDLE);

    always_ff @(posedge i_mclk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            state_reg <= FAS_IDLE;
            cnt_reg <= '0;
            req_reg <= '0;
            ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rdata_reg <= '0;
            loc_reg <= '0;
            addr_reg <= '0;
            ce_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            // Ready drops at the take so a held request is not taken twice
            ready_reg <= ready_next && !take;
            ce_n_reg <= ce_n_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
            dq_oe_reg <= dq_oe_next;
            rsp_valid_reg <= finish;
            if (take)
            begin
                req_reg <= i_req;
                addr_reg <= i_req.addr;
                // Whole 4-byte row is worn; report it to the requester
                loc_reg <= fas_decode(i_req.addr);
            end
            // Sample read data at end of the active window
            // The synchroniser settled one edge earlier, so the byte is steady here
            if (state_reg == FAS_ACTIVE && cnt_done && !req_reg.write)
            begin
                rdata_reg <= dq_sync;
            end
        end
    end

    assign o_req_ready = ready_reg;
    assign o_rsp_valid = rsp_valid_reg;
    assign o_rsp_rdata = rdata_reg;
    assign o_rsp_loc = loc_reg;
    assign o_mem_addr = addr_reg;
    assign o_mem_ce_n = ce_n_reg;
    assign o_mem_we_n = we_n_reg;
    assign o_mem_oe_n = oe_n_reg;
    assign o_mem_dq = req_reg.wdata;
    assign o_mem_dq_oe = dq_oe_reg;
endmodule // fas_host
`default_nettype wire

/* fas_mem_model.sv */
// Purpose: Behavioural byte-wide ferroelectric memory facing fas_host
// Assumes: Data is valid 70 ns after the enable falls
// Notes: Undriven data shows the inverse of the last driven byte
`default_nettype none
module fas_mem_model (
    input wire logic [14:0] i_addr,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:32767];
    logic [7:0] set_regs [0:15];
    int wear [0:8191];
    logic [14:0] lat_addr;
    logic lat_wr;
    logic data_ok;
    logic [7:0] last_q;
    wire logic sel_set = lat_addr >= 15'h7ff0;
    wire logic [7:0] rd = sel_set ? set_regs[lat_addr[3:0]] : mem[lat_addr];
    wire logic drive = !i_ce_n && !lat_wr && !i_oe_n && data_ok;
    assign o_dq = drive ? rd : ~last_q;
    initial
    begin
        for (int k = 0; k < 32768; k++)
        begin
            mem[k] = 8'h00;
            if (k < 8192)
                wear[k] = 0;
            if (k < 16)
                set_regs[k] = 8'h00;
        end
        {lat_addr, lat_wr, data_ok, last_q} = '0;
    end
    // Address and direction are taken only at the falling enable
    always @(negedge i_ce_n)
    begin
        lat_addr = i_addr;
        lat_wr = !i_we_n;
        data_ok = 1'b0;
        if (i_addr < 15'h7ff0)
            wear[{i_addr[14:10], i_addr[7:0]}]++;
        data_ok <= #70 1'b1;
    end
    // The cycle completes even if the host lifts enable early
    always @(posedge i_ce_n)
    begin
        if (lat_wr && sel_set)
            set_regs[lat_addr[3:0]] = i_dq;
        else if (lat_wr)
            mem[lat_addr] = i_dq;
        data_ok = 1'b0;
    end
    always @(rd or drive)
        if (drive)
            last_q = rd;
endmodule // fas_mem_model
`default_nettype wire

/* fas_host_sva.sv */
// Purpose: Pin timing checks for fas_host
// Assumes: Default access and precharge counts
// Notes: Bound from the testbench top file
`default_nettype none
module fas_host_sva
    import fas_pkg::*;
#(
    parameter int PRECHARGE_CYC = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic o_req_ready,
    input wire logic o_rsp_valid,
    input wire fas_loc_t o_rsp_loc,
    input wire logic [14:0] o_mem_addr,
    input wire logic o_mem_ce_n,
    input wire logic o_mem_we_n,
    input wire logic o_mem_oe_n,
    input wire logic o_mem_dq_oe
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // Reset counts as a long precharge so the first access is legal
    logic [7:0] hi_cnt;
    wire logic [7:0] hi_next = (hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01;
    always_ff @(posedge i_mclk or negedge i_rst_n)
        if (!i_rst_n)
            hi_cnt <= 8'hff;
        else
            hi_cnt <= o_mem_ce_n ? hi_next : 8'h00;
    sequence s_fall;
        $fell(o_mem_ce_n);
    endsequence
    sequence s_fall_wr;
        $fell(o_mem_ce_n) && !o_mem_we_n;
    endsequence
    a_addr_steady: assert property (!o_mem_ce_n |-> $stable(o_mem_addr))
        else $error("address moved while enable low");
    a_ce_returns: assert property (s_fall |-> ##[1:30] $rose(o_mem_ce_n))
        else $error("enable stayed low too long");
    a_precharge_gap: assert property (s_fall |-> hi_cnt >= PRECHARGE_CYC)
        else $error("precharge gap too short");
    a_write_setup: assert property (s_fall_wr |-> o_mem_oe_n && o_mem_dq_oe)
        else $error("write started without host data");
    a_write_strobe: assert property (s_fall |-> $stable(o_mem_we_n))
        else $error("write strobe moved at enable fall");
    a_read_quiet: assert property (!o_mem_ce_n && o_mem_we_n |-> !o_mem_dq_oe)
        else $error("host drove data in a read");
    a_idle_quiet: assert property (o_req_ready |-> o_mem_ce_n && !o_mem_dq_oe)
        else $error("pins active while idle");
    a_rsp_pulse: assert property (o_rsp_valid |-> o_mem_ce_n ##1 !o_rsp_valid)
        else $error("response not a single pulse");
    a_loc_decode: assert property (o_rsp_valid |-> o_rsp_loc == {o_mem_addr[14:10],
        o_mem_addr[9:8], o_mem_addr[7:0], o_mem_addr >= 15'h7ff0})
        else $error("location decode wrong");
endmodule // fas_host_sva
`default_nettype wire

/* fas_host_tb.sv */
// Purpose: Self-checking bench for fas_host against a memory model
// Assumes: Default host parameters, 125 MHz clock
// Notes: Inputs change on the falling clock edge
`default_nettype none
`include "fas_defs.svh"
module fas_host_tb
    import fas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [14:0] ADDRS [8] = '{15'h0000, 15'h0001, 15'h0100, 15'h03ff,
        15'h0400, 15'h7fef, 15'h7ff0, 15'h7fff};
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_req_valid = 1'b0;
    fas_req_t i_req = '0;
    logic o_req_ready, o_rsp_valid, o_mem_ce_n, o_mem_we_n, o_mem_oe_n, o_mem_dq_oe;
    logic [7:0] o_rsp_rdata, o_mem_dq, mdq;
    fas_loc_t o_rsp_loc;
    logic [14:0] o_mem_addr;
    wire logic [7:0] i_mem_dq = o_mem_dq_oe ? o_mem_dq : mdq;
    int n_errors = 0;
    int comparisons = 0;
    always #4 i_mclk = ~i_mclk;
    fas_host i_fas_host (.i_mclk, .i_rst_n, .i_req_valid, .i_req, .o_req_ready, .o_rsp_valid,
        .o_rsp_rdata, .o_rsp_loc, .o_mem_addr, .o_mem_ce_n, .o_mem_we_n, .o_mem_oe_n,
        .i_mem_dq, .o_mem_dq, .o_mem_dq_oe);
    fas_mem_model i_fas_mem_model (.i_addr(o_mem_addr), .i_ce_n(o_mem_ce_n),
        .i_we_n(o_mem_we_n), .i_oe_n(o_mem_oe_n), .i_dq(i_mem_dq), .o_dq(mdq));
    // ==========================================
    // Compare and transfer tasks
    task automatic fail_line(input logic [31:0] got, input logic [31:0] exp);
        n_errors++;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
            fail_line(32'(got), 32'(exp));
    endtask
    task automatic cmp_loc(input fas_loc_t got, input fas_loc_t exp);
        comparisons++;
        if (got !== exp)
            fail_line(32'(got), 32'(exp));
    endtask
    task automatic cmp_int(input int got, input int exp);
        comparisons++;
        if (got != exp)
            fail_line(got, exp);
    endtask
    function automatic fas_loc_t exp_loc(input logic [14:0] a);
        return '{a[14:10], a[9:8], a[7:0], a >= 15'h7ff0};
    endfunction
    task automatic finish_test();
        $display("n_errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Presents the request once idle shows, drops it after the take edge
    task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 300)
        begin
            @(negedge i_mclk);
            n++;
        end
        i_req = '{wr, a, d};
        i_req_valid = 1'b1;
        @(negedge i_mclk);
        n++;
        i_req_valid = 1'b0;
        while (o_rsp_valid !== 1'b1 && n < 300)
        begin
            @(negedge i_mclk);
            n++;
        end
        if (n >= 300)
        begin
            n_errors++;
            finish_test();
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_rows();
        for (int k = 0; k < 8; k++)
            access(1'b1, ADDRS[k], 8'h30 + 8'(k));
        for (int k = 0; k < 8; k++)
        begin
            access(1'b0, ADDRS[k], 8'h00);
            cmp8(o_rsp_rdata, 8'h30 + 8'(k));
            cmp_loc(o_rsp_loc, exp_loc(ADDRS[k]));
        end
    endtask
    task automatic t_wear();
        cmp_int(i_fas_mem_model.wear[0], 4);
        cmp_int(i_fas_mem_model.wear[1], 2);
        cmp_int(i_fas_mem_model.wear[255], 2);
        cmp_int(i_fas_mem_model.wear[256], 2);
    endtask
    task automatic t_settings();
        access(1'b1, 15'h7ff5, 8'ha5);
        access(1'b0, 15'h7ff5, 8'h00);
        cmp8(o_rsp_rdata, 8'ha5);
        cmp8(i_fas_mem_model.mem[15'h7ff5], 8'h00);
        cmp8(i_fas_mem_model.mem[15'h7fef], 8'h35);
    endtask
    // Reset mid-run: pins go idle, the array keeps its bytes, access resumes
    task automatic t_reset();
        i_rst_n = 1'b0;
        @(negedge i_mclk);
        cmp8({4'h0, o_mem_ce_n, o_mem_we_n, o_mem_oe_n, o_mem_dq_oe}, 8'h0e);
        cmp8({6'h00, o_req_ready, o_rsp_valid}, 8'h00);
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst_n = 1'b1;
        access(1'b0, ADDRS[1], 8'h00);
        cmp8(o_rsp_rdata, 8'h31);
        cmp_loc(o_rsp_loc, exp_loc(ADDRS[1]));
    endtask
    initial
    begin
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst_n = 1'b1;
        t_rows();
        t_wear();
        t_settings();
        t_reset();
        finish_test();
    end
endmodule // fas_host_tb
bind fas_host fas_host_sva #(.PRECHARGE_CYC(PRECHARGE_CYC)) i_fas_host_sva (.i_mclk,
    .i_rst_n, .o_req_ready, .o_rsp_valid, .o_rsp_loc, .o_mem_addr, .o_mem_ce_n,
    .o_mem_we_n, .o_mem_oe_n, .o_mem_dq_oe);
`default_nettype wire
